// file: port_tuning_pkg.sv
// holds offsets, field positions, reset values and encodings of the port tuning registers
// assumes a configuration access port with dword offsets on the switch core clock
package port_tuning_pkg;

   // ******************************************************************
   // offsets
   // ******************************************************************
   localparam logic [7:0]  OFS_TEST_CTRL_0   = 8'h68;
   localparam logic [7:0]  OFS_TEST_CTRL_1   = 8'h6C;
   localparam logic [7:0]  OFS_TIMER_WORD    = 8'h70;
   localparam logic [7:0]  OFS_SWITCH_MODE   = 8'h74;

   // ******************************************************************
   // reset values
   // ******************************************************************
   localparam logic [31:0] RST_TEST_CTRL_0   = 32'h0400_1060;
   localparam logic [31:0] RST_TEST_CTRL_1   = 32'h0400_0800;
   localparam logic [11:0] RST_USER_REPLAY   = 12'h000;
   localparam logic [13:0] RST_USER_ACK      = 14'h0000;
   localparam logic        RST_VGA_DECODE    = 1'b1;
   localparam logic [1:0]  RST_CT_THRESHOLD  = 2'h1;

   // ******************************************************************
   // field positions
   // ******************************************************************
   localparam int          TC0_ROLE_CHG_EN   = 1;
   localparam int          TC0_NO_HOT_RESET  = 2;
   localparam int          TC0_ROLE_DOWN     = 3;
   localparam int          TC0_EE_LO         = 13;
   localparam int          TC0_EE_HI         = 14;
   localparam int          TW_REPLAY_LO      = 0;
   localparam int          TW_REPLAY_EN      = 12;
   localparam int          TW_PM_CAP_DIS     = 13;
   localparam int          TW_MSI_CAP_DIS    = 14;
   localparam int          TW_ACK_LO         = 16;
   localparam int          TW_ACK_EN         = 30;
   localparam int          TW_VGA_DECODE     = 31;
   localparam int          SM_STORE_FWD      = 0;
   localparam int          SM_THRESH_LO      = 1;

   // ******************************************************************
   // cut-through threshold encodings
   // ******************************************************************
   typedef enum logic [1:0] {
      CT_MIDPOINT = 2'h0,
      CT_AHEAD_1  = 2'h1,
      CT_AHEAD_2  = 2'h2,
      CT_AHEAD_3  = 2'h3
   } ct_threshold_t;

   // ******************************************************************
   // internal replay/ack defaults, a plain table stand-in per width
   // ******************************************************************
   localparam logic [11:0] DEF_REPLAY_X1     = 12'h2C2;
   localparam logic [13:0] DEF_ACK_X1        = 14'h00ED;

endpackage : port_tuning_pkg

// file: timer_select.sv
// holds the chooser between a user timer value and the internally derived one
// assumes link width and speed come from the same clock domain
`timescale 1ns/1ps
module timer_select #(
   parameter int W = 12
) (
   // control
   input  wire logic         use_user_i,
   input  wire logic [W-1:0] user_val_i,
   input  wire logic [W-1:0] base_val_i,
   input  wire logic [2:0]   width_code_i,
   input  wire logic         gen2_i,
   // result
   output logic [W-1:0]      val_o
);
   // internal figure doubles with each step of the width code and halves at the higher rate
   logic [W-1:0] scaled;
   logic [W-1:0] internal_val;
   assign scaled       = base_val_i << width_code_i;
   assign internal_val = gen2_i ? (scaled >> 1) : scaled;
   assign val_o        = use_user_i ? user_val_i : internal_val;
endmodule : timer_select

// file: switch_port_tuning_regs.sv
// holds the vendor tuning registers of one switch port and their effect on the port's logic
// assumes a single-cycle config access port and a loader port used by smbus/i2c/eeprom logic
//
// Functional notes
// - bit 1 of test control 0 permits (1) or forbids (0) changing the link training role.
// - on the upstream port bit 2 of test control 0 set stops hot reset propagation on upstream link loss.
// - bit 3 of test control 0 picks downstream (1) or upstream (0) link training role.
// - test control 0 resets to 0400_1060h, with bits 14:13 optionally taken from eeprom autoload.
// - timer word bits 11:0 hold a writable user replay timeout resetting to zero.
// - timer word bit 12 makes the link layer use the user replay timeout.
// - timer word bits 29:16 hold a writable user ack latency resetting to zero.
// - timer word bit 30 makes the device use the user ack latency.
// - timer word bit 31 is read-only, resets to one, and enables vga range decode.
// - switch mode bit 0 selects store-and-forward (1) or cut-through (0) on the upstream port.
// - switch mode bits 2:1 set the slow-to-fast cut-through start point, reset 01b.
// - defaults of the timer word and switch mode fields may be replaced by an smbus/i2c master or eeprom autoload.
`timescale 1ns/1ps
module switch_port_tuning_regs #(
   parameter bit IS_UPSTREAM = 1'b1
) (
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   // configuration access
   input  wire logic        CFG_WR_I,
   input  wire logic        CFG_RD_I,
   input  wire logic [7:0]  CFG_ADDR_I,
   input  wire logic [3:0]  CFG_BE_I,
   input  wire logic [31:0] CFG_WDATA_I,
   output logic [31:0]      CFG_RDATA_O,
   output logic             CFG_HIT_O,
   // default loader (smbus, i2c, eeprom)
   input  wire logic        LOAD_WR_I,
   input  wire logic [7:0]  LOAD_ADDR_I,
   input  wire logic [31:0] LOAD_DATA_I,
   // port state
   input  wire logic        UP_LINK_DOWN_I,
   input  wire logic        ROLE_DOWN_REQ_I,
   input  wire logic [2:0]  LINK_WIDTH_I,
   input  wire logic        LINK_GEN2_I,
   input  wire logic        SLOW_TO_FAST_I,
   // controls to the port
   output logic             DOWNSTREAM_ROLE_SELECT_O,
   output logic             HOT_RESET_FWD_O,
   output logic [11:0]      REPLAY_TIMEOUT_O,
   output logic [13:0]      ACK_LATENCY_O,
   output logic             VGA_DECODE_O,
   output logic             STORE_FORWARD_O,
   output logic [1:0]       CT_THRESHOLD_O,
   output logic             PM_CAP_DISABLE_O,
   output logic             MSI_CAP_DISABLE_O
);

   // ******************************************************************
   // registers
   // ******************************************************************
   logic [31:0] tc0_reg,   tc0_next;
   logic [31:0] tc1_reg,   tc1_next;
   logic [11:0] replay_reg, replay_next;
   logic        replay_en_reg, replay_en_next;
   logic        pm_dis_reg, pm_dis_next;
   logic        msi_dis_reg, msi_dis_next;
   logic [13:0] ack_reg,   ack_next;
   logic        ack_en_reg, ack_en_next;
   logic        vga_reg,   vga_next;
   logic        sf_reg,    sf_next;
   logic [1:0]  thr_reg,   thr_next;
   logic        role_reg,  role_next;
   logic [31:0] rdata_q;
   logic        hit_q;

   // ******************************************************************
   // decode
   // ******************************************************************
   wire         hit_tc0 = CFG_ADDR_I == port_tuning_pkg::OFS_TEST_CTRL_0;
   wire         hit_tc1 = CFG_ADDR_I == port_tuning_pkg::OFS_TEST_CTRL_1;
   wire         hit_tw  = CFG_ADDR_I == port_tuning_pkg::OFS_TIMER_WORD;
   wire         hit_sm  = (CFG_ADDR_I == port_tuning_pkg::OFS_SWITCH_MODE) && IS_UPSTREAM;
   wire         hit_any = hit_tc0 | hit_tc1 | hit_tw | hit_sm;
   // the loader writes whole words and needs no byte enables
   wire         ld_tc0  = LOAD_WR_I && LOAD_ADDR_I == port_tuning_pkg::OFS_TEST_CTRL_0;
   wire         ld_tw   = LOAD_WR_I && LOAD_ADDR_I == port_tuning_pkg::OFS_TIMER_WORD;
   wire         ld_sm   = LOAD_WR_I && LOAD_ADDR_I == port_tuning_pkg::OFS_SWITCH_MODE;
   // byte enables merge the new lanes over the present register image
   wire [31:0]  be_mask = {{8{CFG_BE_I[3]}}, {8{CFG_BE_I[2]}}, {8{CFG_BE_I[1]}}, {8{CFG_BE_I[0]}}};
   wire [31:0]  wd_tc0  = (tc0_reg & ~be_mask) | (CFG_WDATA_I & be_mask);
   wire [31:0]  wd_tc1  = (tc1_reg & ~be_mask) | (CFG_WDATA_I & be_mask);
   wire [31:0]  tw_word = {vga_reg, ack_en_reg, ack_reg, 1'b0, msi_dis_reg, pm_dis_reg,
                           replay_en_reg, replay_reg};
   wire [31:0]  wd_tw   = (tw_word & ~be_mask) | (CFG_WDATA_I & be_mask);
   wire [31:0]  sm_word = {29'h0, thr_reg, sf_reg};
   wire [31:0]  wd_sm   = (sm_word & ~be_mask) | (CFG_WDATA_I & be_mask);
   wire         wr_tc0  = CFG_WR_I && hit_tc0;
   wire         wr_tw   = CFG_WR_I && hit_tw;
   wire         wr_sm   = CFG_WR_I && hit_sm;
   // host writes win over a loader write landing in the same cycle, except the read-only timer word bits, which take the loader data
   wire [31:0]  tw_src  = wr_tw ? wd_tw : LOAD_DATA_I;
   wire         tw_upd  = wr_tw | ld_tw;
   wire [31:0]  sm_src  = wr_sm ? wd_sm : LOAD_DATA_I;
   wire         sm_upd  = wr_sm | ld_sm;

   // ******************************************************************
   // next state
   // ******************************************************************
   always_comb begin
      tc0_next = tc0_reg;
      if (wr_tc0) begin
         tc0_next = wd_tc0;
      end else if (ld_tc0) begin
         // autoload may only replace the two loadable bits
         tc0_next[port_tuning_pkg::TC0_EE_HI:port_tuning_pkg::TC0_EE_LO] =
            LOAD_DATA_I[port_tuning_pkg::TC0_EE_HI:port_tuning_pkg::TC0_EE_LO];
      end
   end

   // test control 1 is plain storage with no effect on the port, and the loader cannot reach it
   assign tc1_next       = (CFG_WR_I && hit_tc1) ? wd_tc1 : tc1_reg;
   assign replay_next    = tw_upd ? tw_src[port_tuning_pkg::TW_REPLAY_LO +: 12] : replay_reg;
   assign replay_en_next = tw_upd ? tw_src[port_tuning_pkg::TW_REPLAY_EN] : replay_en_reg;
   assign ack_next       = tw_upd ? tw_src[port_tuning_pkg::TW_ACK_LO +: 14] : ack_reg;
   assign ack_en_next    = tw_upd ? tw_src[port_tuning_pkg::TW_ACK_EN] : ack_en_reg;
   // read-only bits change only through the loader
   assign pm_dis_next    = ld_tw ? LOAD_DATA_I[port_tuning_pkg::TW_PM_CAP_DIS] : pm_dis_reg;
   assign msi_dis_next   = ld_tw ? LOAD_DATA_I[port_tuning_pkg::TW_MSI_CAP_DIS] : msi_dis_reg;
   assign vga_next       = ld_tw ? LOAD_DATA_I[port_tuning_pkg::TW_VGA_DECODE] : vga_reg;
   assign sf_next        = sm_upd ? sm_src[port_tuning_pkg::SM_STORE_FWD] : sf_reg;
   assign thr_next       = sm_upd ? sm_src[port_tuning_pkg::SM_THRESH_LO +: 2] : thr_reg;
   // role follows the select bit ORed with the down request only while changes are permitted
   assign role_next      = tc0_reg[port_tuning_pkg::TC0_ROLE_CHG_EN]
                           ? (tc0_reg[port_tuning_pkg::TC0_ROLE_DOWN] | ROLE_DOWN_REQ_I) : role_reg;

   // ******************************************************************
   // state
   // ******************************************************************
   // enables and capability flags come up clear; only the vga decode flag comes up set
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         tc0_reg       <= port_tuning_pkg::RST_TEST_CTRL_0;
         tc1_reg       <= port_tuning_pkg::RST_TEST_CTRL_1;
         replay_reg    <= port_tuning_pkg::RST_USER_REPLAY;
         replay_en_reg <= 1'b0;
         pm_dis_reg    <= 1'b0;
         msi_dis_reg   <= 1'b0;
         ack_reg       <= port_tuning_pkg::RST_USER_ACK;
         ack_en_reg    <= 1'b0;
         vga_reg       <= port_tuning_pkg::RST_VGA_DECODE;
         sf_reg        <= 1'b0;
         thr_reg       <= port_tuning_pkg::RST_CT_THRESHOLD;
         role_reg      <= 1'b0;
      end else begin
         tc0_reg       <= tc0_next;
         tc1_reg       <= tc1_next;
         replay_reg    <= replay_next;
         replay_en_reg <= replay_en_next;
         pm_dis_reg    <= pm_dis_next;
         msi_dis_reg   <= msi_dis_next;
         ack_reg       <= ack_next;
         ack_en_reg    <= ack_en_next;
         vga_reg       <= vga_next;
         sf_reg        <= sf_next;
         thr_reg       <= thr_next;
         role_reg      <= role_next;
      end
   end

   // ******************************************************************
   // read port
   // ******************************************************************
   // reserved bits and unmapped offsets read as zero
   wire [31:0] rd_mux = hit_tc0 ? tc0_reg :
                        hit_tc1 ? tc1_reg :
                        hit_tw  ? tw_word :
                        hit_sm  ? sm_word : 32'h0000_0000;

   // hit answers writes as well, so software can spot a dead offset without a read-back
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rdata_q <= 32'h0000_0000;
         hit_q   <= 1'b0;
      end else begin
         rdata_q <= CFG_RD_I ? rd_mux : 32'h0000_0000;
         hit_q   <= (CFG_RD_I | CFG_WR_I) & hit_any;
      end
   end

   assign CFG_RDATA_O = rdata_q;
   assign CFG_HIT_O   = hit_q;

   // ******************************************************************
   // controls to the port
   // ******************************************************************
   assign DOWNSTREAM_ROLE_SELECT_O = role_reg;
   // downstream ports never drive hot reset from upstream loss
   assign HOT_RESET_FWD_O = IS_UPSTREAM && UP_LINK_DOWN_I && !tc0_reg[port_tuning_pkg::TC0_NO_HOT_RESET];
   assign VGA_DECODE_O     = vga_reg;
   assign STORE_FORWARD_O  = IS_UPSTREAM && sf_reg;
   // threshold only matters in cut-through from a slower ingress
   assign CT_THRESHOLD_O   = (SLOW_TO_FAST_I && !sf_reg) ? thr_reg : port_tuning_pkg::CT_MIDPOINT;
   assign PM_CAP_DISABLE_O  = pm_dis_reg;
   assign MSI_CAP_DISABLE_O = msi_dis_reg;

   // one chooser per timer; width and rate scale only the internal figure, never the user one
   timer_select #(.W(12)) u_replay_sel (
      .use_user_i   (replay_en_reg),
      .user_val_i   (replay_reg),
      .base_val_i   (port_tuning_pkg::DEF_REPLAY_X1),
      .width_code_i (LINK_WIDTH_I),
      .gen2_i       (LINK_GEN2_I),
      .val_o        (REPLAY_TIMEOUT_O)
   );

   timer_select #(.W(14)) u_ack_sel (
      .use_user_i   (ack_en_reg),
      .user_val_i   (ack_reg),
      .base_val_i   (port_tuning_pkg::DEF_ACK_X1),
      .width_code_i (LINK_WIDTH_I),
      .gen2_i       (LINK_GEN2_I),
      .val_o        (ACK_LATENCY_O)
   );

endmodule : switch_port_tuning_regs

// file: switch_port_tuning_regs_asserts.sv
// assertions on the port tuning registers, bound to every instance
// assumes the upstream build and a single-cycle config access port
`timescale 1ns/1ps
module switch_port_tuning_regs_asserts (
   // watched ports
   input wire logic        CLK_I,
   input wire logic        RST_N_I,
   input wire logic        CFG_WR_I,
   input wire logic        CFG_RD_I,
   input wire logic [7:0]  CFG_ADDR_I,
   input wire logic [3:0]  CFG_BE_I,
   input wire logic [31:0] CFG_WDATA_I,
   input wire logic [31:0] CFG_RDATA_O,
   input wire logic        CFG_HIT_O,
   input wire logic        LOAD_WR_I,
   input wire logic        UP_LINK_DOWN_I,
   input wire logic        SLOW_TO_FAST_I,
   input wire logic        HOT_RESET_FWD_O,
   input wire logic [11:0] REPLAY_TIMEOUT_O,
   input wire logic [13:0] ACK_LATENCY_O,
   input wire logic        VGA_DECODE_O,
   input wire logic        STORE_FORWARD_O,
   input wire logic [1:0]  CT_THRESHOLD_O
);
   // ****
   // decode
   // ****
   wire logic mapped = CFG_ADDR_I inside {8'h68, 8'h6C, 8'h70, 8'h74};
   // a same-cycle loader write is left out because it may legally change the read-only vga flag that a_vga_readonly watches
   wire logic wr_tw  = CFG_WR_I && !LOAD_WR_I && CFG_ADDR_I == 8'h70;
   wire logic wr_sm  = CFG_WR_I && CFG_BE_I[0] && CFG_ADDR_I == 8'h74;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   a_read_hit: assert property (CFG_RD_I && mapped |=> CFG_HIT_O)
      else $error("mapped read gave no hit");
   a_unmapped_quiet: assert property (CFG_RD_I && !mapped |=> !CFG_HIT_O && CFG_RDATA_O == 32'h0)
      else $error("unmapped read answered");
   a_hot_cause: assert property (HOT_RESET_FWD_O |-> UP_LINK_DOWN_I)
      else $error("hot reset without link loss");
   a_replay_user: assert property (
      wr_tw && CFG_BE_I[1:0] == 2'h3 && CFG_WDATA_I[12] |=> REPLAY_TIMEOUT_O == $past(CFG_WDATA_I[11:0]))
      else $error("user replay value not applied");
   a_ack_user: assert property (
      wr_tw && CFG_BE_I[3:2] == 2'h3 && CFG_WDATA_I[30] |=> ACK_LATENCY_O == $past(CFG_WDATA_I[29:16]))
      else $error("user ack latency not applied");
   a_vga_readonly: assert property (wr_tw && CFG_BE_I[3] |=> $stable(VGA_DECODE_O))
      else $error("vga flag took a host write");
   a_store_fwd: assert property (wr_sm |=> STORE_FORWARD_O == $past(CFG_WDATA_I[0]))
      else $error("store-forward bit not applied");
   a_ct_follow: assert property (
      wr_sm && !CFG_WDATA_I[0] ##1 SLOW_TO_FAST_I |-> CT_THRESHOLD_O == $past(CFG_WDATA_I[2:1]))
      else $error("threshold not applied");
   a_ct_idle: assert property (STORE_FORWARD_O || !SLOW_TO_FAST_I |-> CT_THRESHOLD_O == 2'h0)
      else $error("threshold outside cut-through");
   c_hot: cover property (HOT_RESET_FWD_O);
   c_user: cover property (wr_tw ##1 REPLAY_TIMEOUT_O != 12'h0);
   c_sf: cover property (STORE_FORWARD_O);
endmodule : switch_port_tuning_regs_asserts

bind switch_port_tuning_regs switch_port_tuning_regs_asserts i_chk (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CFG_WR_I(CFG_WR_I), .CFG_RD_I(CFG_RD_I), .CFG_ADDR_I(CFG_ADDR_I),
   .CFG_BE_I(CFG_BE_I), .CFG_WDATA_I(CFG_WDATA_I), .CFG_RDATA_O(CFG_RDATA_O), .CFG_HIT_O(CFG_HIT_O),
   .LOAD_WR_I(LOAD_WR_I), .UP_LINK_DOWN_I(UP_LINK_DOWN_I), .SLOW_TO_FAST_I(SLOW_TO_FAST_I),
   .HOT_RESET_FWD_O(HOT_RESET_FWD_O), .REPLAY_TIMEOUT_O(REPLAY_TIMEOUT_O), .ACK_LATENCY_O(ACK_LATENCY_O),
   .VGA_DECODE_O(VGA_DECODE_O), .STORE_FORWARD_O(STORE_FORWARD_O), .CT_THRESHOLD_O(CT_THRESHOLD_O));

// file: default_loader_model.sv
// model of the smbus, i2c and eeprom default loader
// assumes the core clock; one word per pulse
`timescale 1ns/1ps
module default_loader_model (
   // clock
   input  wire logic        clk_i,
   // loader port
   output logic             load_wr_o,
   output logic [7:0]       load_addr_o,
   output logic [31:0]      load_data_o
);
   initial begin
      load_wr_o   = 1'b0;
      load_addr_o = 8'h00;
      load_data_o = 32'h0;
   end
   // after the pulse the bus shows the inverse, so stale data never passes for a held word
   task automatic load(input logic [7:0] addr, input logic [31:0] data);
      @(posedge clk_i);
      load_wr_o   <= 1'b1;
      load_addr_o <= addr;
      load_data_o <= data;
      @(posedge clk_i);
      load_wr_o   <= 1'b0;
      load_addr_o <= ~addr;
      load_data_o <= ~data;
   endtask : load
endmodule : default_loader_model

// file: switch_port_tuning_regs_test.sv
// self-checking bench for the port tuning registers with a default loader model
// assumes the upstream build; link width code and rate start at 0 and 2.5 GT/s, where the internal timers sit at base
`timescale 1ns/1ps
module switch_port_tuning_regs_test;
   // ****
   // signals
   // ****
   logic        clk, rst_n, wr, rd, link_down, s2f, hit, role, hot, vga, sfwd, ld_wr, rd_seen;
   logic [7:0]  addr, ld_addr;
   logic [7:0]  lfsr = 8'h2D;
   logic [3:0]  be;
   logic [31:0] wdata, rdata, ld_data;
   logic [32:0] exp_q[$];
   logic [11:0] rpl;
   logic [2:0]  lw;
   logic        g2, req, pm, msi;
   logic [13:0] ack;
   logic [1:0]  ct;
   int          fails = 0;
   int          total_checks = 0;
   int          cycles = 0;
   switch_port_tuning_regs i_dut (
      .CLK_I(clk), .RST_N_I(rst_n), .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_ADDR_I(addr), .CFG_BE_I(be),
      .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_HIT_O(hit), .LOAD_WR_I(ld_wr), .LOAD_ADDR_I(ld_addr),
      .LOAD_DATA_I(ld_data), .UP_LINK_DOWN_I(link_down), .ROLE_DOWN_REQ_I(req), .LINK_WIDTH_I(lw),
      .LINK_GEN2_I(g2), .SLOW_TO_FAST_I(s2f), .DOWNSTREAM_ROLE_SELECT_O(role), .HOT_RESET_FWD_O(hot),
      .REPLAY_TIMEOUT_O(rpl), .ACK_LATENCY_O(ack), .VGA_DECODE_O(vga), .STORE_FORWARD_O(sfwd),
      .CT_THRESHOLD_O(ct), .PM_CAP_DISABLE_O(pm), .MSI_CAP_DISABLE_O(msi));
   default_loader_model i_ldr (.clk_i(clk), .load_wr_o(ld_wr), .load_addr_o(ld_addr), .load_data_o(ld_data));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction : rnd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // read results carry the hit flag above the data word
   task automatic chk_read(input logic [32:0] got, input logic [32:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t read got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_read
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge clk);
      wr    <= w;
      rd    <= !w;
      addr  <= a;
      be    <= b;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
      rd    <= 1'b0;
   endtask : access
   task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back({(a inside {port_tuning_pkg::OFS_TEST_CTRL_0, port_tuning_pkg::OFS_TEST_CTRL_1,
                                  port_tuning_pkg::OFS_TIMER_WORD, port_tuning_pkg::OFS_SWITCH_MODE}), e});
      access(1'b0, a, 4'h0, 32'h0);
   endtask : rd_exp
   // ****
   // read monitor and timeout
   // ****
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk) begin
      if (rd_seen && exp_q.size() > 0) chk_read({hit, rdata}, exp_q.pop_front());
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      logic [11:0] r;
      logic [13:0] k;
      int          t;
      {rst_n, wr, rd, addr, be, wdata, link_down, s2f} = {1'b0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0, 1'b0, 1'b1};
      {lw, g2, req} = 5'h00;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd_exp(8'h68, port_tuning_pkg::RST_TEST_CTRL_0);
      rd_exp(8'h6C, port_tuning_pkg::RST_TEST_CTRL_1);
      rd_exp(8'h70, 32'h8000_0000);
      rd_exp(8'h74, 32'h0000_0002);
      rd_exp(8'h7C, 32'h0);
      $display("test reset done");
      r = 12'({rnd(), rnd()});
      k = 14'({rnd(), rnd()});
      access(1'b1, 8'h70, 4'hF, {2'b01, k, 4'hF, r});
      @(negedge clk);
      chk(32'(rpl), 32'(r));
      chk(32'(ack), 32'(k));
      rd_exp(8'h70, {2'b11, k, 4'h1, r});
      access(1'b1, 8'h70, 4'hF, 32'h0);
      @(negedge clk);
      chk(32'(rpl), 32'(port_tuning_pkg::DEF_REPLAY_X1));
      chk(32'(ack), 32'(port_tuning_pkg::DEF_ACK_X1));
      @(posedge clk);
      lw <= 3'h1;
      @(negedge clk);
      chk(32'(rpl), 32'(port_tuning_pkg::DEF_REPLAY_X1) * 32'h2);
      chk(32'(ack), 32'(port_tuning_pkg::DEF_ACK_X1) * 32'h2);
      @(posedge clk);
      g2 <= 1'b1;
      @(negedge clk);
      chk(32'(rpl), 32'(port_tuning_pkg::DEF_REPLAY_X1));
      chk(32'(ack), 32'(port_tuning_pkg::DEF_ACK_X1));
      @(posedge clk);
      lw <= 3'h0;
      g2 <= 1'b0;
      access(1'b1, 8'h70, 4'h1, 32'hFFFF_FFFF);
      rd_exp(8'h70, 32'h8000_00FF);
      $display("test timer done");
      link_down <= 1'b1;
      access(1'b1, 8'h68, 4'hF, 32'h0000_000A);
      @(posedge clk);
      @(negedge clk);
      chk(32'(role), 32'h1);
      chk(32'(hot), 32'h1);
      access(1'b1, 8'h68, 4'hF, 32'h0000_0004);
      @(posedge clk);
      @(negedge clk);
      chk(32'(role), 32'h1);
      chk(32'(hot), 32'h0);
      access(1'b1, 8'h68, 4'hF, 32'h0000_0002);
      @(posedge clk);
      @(negedge clk);
      chk(32'(role), 32'h0);
      @(posedge clk);
      req <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk(32'(role), 32'h1);
      @(posedge clk);
      req <= 1'b0;
      $display("test role done");
      i_ldr.load(8'h68, 32'hFFFF_FFFF);
      rd_exp(8'h68, 32'h0000_6002);
      i_ldr.load(8'h70, 32'h0000_7ABC);
      @(negedge clk);
      chk(32'(rpl), 32'hABC);
      chk(32'(vga), 32'h0);
      chk(32'({pm, msi}), 32'h3);
      $display("test loader done");
      for (t = 0; t < 4; t++) begin
         access(1'b1, 8'h74, 4'h1, 32'(t << 1));
         @(negedge clk);
         chk(32'(ct), 32'(t));
         chk(32'(sfwd), 32'h0);
      end
      @(posedge clk);
      s2f <= 1'b0;
      @(negedge clk);
      chk(32'(ct), 32'h0);
      @(posedge clk);
      s2f <= 1'b1;
      access(1'b1, 8'h74, 4'h1, 32'h7);
      @(negedge clk);
      chk(32'(sfwd), 32'h1);
      chk(32'(ct), 32'h0);
      rd_exp(8'h74, 32'h7);
      $display("test forwarding done");
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_exp(8'h70, 32'h8000_0000);
      rd_exp(8'h74, 32'h0000_0002);
      $display("test second reset done");
      repeat (3) @(posedge clk);
      close_out();
   end
endmodule : switch_port_tuning_regs_test
